/* File: hw/tbc_pkg.sv */
// Package: constants and types for the triggered binary timer/counter
package tbc_pkg;
   // ==========================================================
   // Clock and time base
   localparam int unsigned CLK_PERIOD_NS = 8;
   // Internal oscillator period; the real one is set by outside parts
   localparam int unsigned TB_PERIOD_NS = 8000;
   localparam int unsigned TB_HALF_CYCLES =
      TB_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int unsigned DIV_W = $clog2(TB_HALF_CYCLES);
   // Least pulse widths the outside party must give
   localparam int unsigned TRIG_MIN_US = 2;
   localparam int unsigned TRIG_MIN_CYCLES =
      (TRIG_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned EXT_CLK_MIN_US = 1;
   localparam int unsigned EXT_CLK_MIN_CYCLES =
      (EXT_CLK_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ==========================================================
   // Counter
   localparam int unsigned COUNT_W = 8;
   localparam logic [COUNT_W-1:0] COUNT_RESET_VAL = 8'hFF;
   localparam logic [COUNT_W-1:0] COUNT_START_VAL = 8'h00;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TB_HALF_CYCLES - 1);
   localparam logic [DIV_W-1:0] DIV_ZERO = '0;
   // ==========================================================
   // Control state
   typedef enum logic [2:0] {
      ST_RESET = 3'b001,
      ST_ARMED = 3'b010,
      ST_COUNT = 3'b100
   } tbc_ctrl_t;
endpackage

/* File: hw/tbc_tb_if.sv */
// Interface: control link between counter logic and time-base divider
interface tbc_tb_if;
   logic run;
   logic half_tick;
   modport ctrl (output run, input half_tick);
   modport osc (input run, output half_tick);
endinterface

/* File: hw/tbc_timebase.sv */
// Time-base divider: half-period enable pulses while running
module tbc_timebase
   import tbc_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   tbc_tb_if.osc tb
);
   import tbc_pkg::*;

   typedef struct packed {
      logic [DIV_W-1:0] div;
      logic tick;
   } tbc_div_t;

   tbc_div_t div_reg;
   tbc_div_t div_next;

   // ==========================================================
   // Divider
   always_comb begin
      div_next = div_reg;
      div_next.tick = 1'b0;
      if (!tb.run) begin
         // Restart phase so the first half period is full length
         div_next.div = DIV_ZERO;
      end else if (div_reg.div == DIV_LAST) begin
         div_next.div = DIV_ZERO;
         div_next.tick = 1'b1;
      end else begin
         div_next.div = DIV_W'(div_reg.div + 1'b1);
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_next;
      end
   end

   assign tb.half_tick = div_reg.tick;
endmodule

/* File: hw/tbc_top.sv */
// Triggered 8-bit binary timer/counter with time-base control
//
// Contract
// R1: Counter advances only on a falling edge at the time-base pin.
// R2: Accepted reset stops oscillator, releases all count and time-base pins.
// R3: Trigger from reset starts oscillator; first fall clears count to zero.
// R4: Once triggered, trigger input is ignored until a reset is accepted.
// R5: Reset high with trigger low sets outputs high, halts oscillator.
// R6: Reset arriving while trigger is high is ignored.
// R7: Reset still high when trigger falls is then performed.
// R8: Power-up comes up in reset state, outputs high, oscillator stopped.
// R9: Count outputs are open-collector; any low pulls a shared line low.
// R10: Outputs fed back to reset give pulse of summed bit weights.
// R11: Delays of 1 to 255 periods follow from the feedback choice.
// R12: Without feedback the counter free-runs until an external reset.
// R13: Pin accepts external clock; holding it low pauses counting.
// R14: Outside party holds trigger and reset high at least 2 us.
// R15: External clock pulses last 1 us or more, up to 1.5 MHz.
// R16: Each count output serves alone as a divided time-base frequency.
// R17: Bit n weighs two to the n; its period is 2^(n+1) periods.
module tbc_top
   import tbc_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic trigger_i,
   input wire logic reset_req_i,
   input wire logic timebase_i,
   input wire logic timebase_disable_i,
   output logic [tbc_pkg::COUNT_W-1:0] binary_count_outputs_o,
   output logic [tbc_pkg::COUNT_W-1:0] binary_count_outputs_oe_o,
   output logic timebase_pulse_out_o,
   output logic timebase_pulse_out_oe_o
);
   import tbc_pkg::*;

   typedef struct packed {
      tbc_ctrl_t ctrl;
      logic [COUNT_W-1:0] count;
      logic tb_prev;
      logic [COUNT_W-1:0] q_oe;
      logic tbo_oe;
      logic run;
      logic init_done;
   } tbc_core_t;

   tbc_core_t core_reg;
   tbc_core_t core_next;

   tbc_tb_if tb_link ();

   // ==========================================================
   // Time-base divider
   tbc_timebase u_timebase (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .tb (tb_link.osc)
   );

   assign tb_link.run = core_reg.run;

   // ==========================================================
   // Decode helpers
   logic tb_fall;
   logic reset_accept;

   // Holding the pin low gives no fall, so counting pauses in place
   assign tb_fall = core_reg.tb_prev & ~timebase_i; // R1 R13

   // Reset is gated by the trigger level; a held reset waits for it
   assign reset_accept = reset_req_i & ~trigger_i; // R5 R6 R7

   // Open-collector drive: enable pulls low wherever the bit is zero
   function automatic logic [COUNT_W-1:0] pull_low(
      input tbc_ctrl_t ctrl,
      input logic [COUNT_W-1:0] count
   );
      if (ctrl == ST_COUNT) begin
         pull_low = ~count;
      end else begin
         pull_low = '0;
      end
   endfunction

   // ==========================================================
   // Control and counter
   always_comb begin
      core_next = core_reg;
      core_next.tb_prev = timebase_i;
      core_next.init_done = 1'b1;
      case (core_reg.ctrl)
         ST_RESET: begin
            core_next.count = COUNT_RESET_VAL;
            // Trigger wins over a simultaneous reset request
            if (trigger_i) begin
               core_next.ctrl = ST_ARMED; // R3
            end
         end
         ST_ARMED: begin
            if (reset_accept) begin
               core_next.ctrl = ST_RESET; // R2 R5 R7
            end else if (tb_fall) begin
               core_next.ctrl = ST_COUNT; // R3
               core_next.count = COUNT_START_VAL; // R3
            end
         end
         ST_COUNT: begin
            // Trigger is looked at here only through reset_accept
            if (reset_accept) begin
               core_next.ctrl = ST_RESET; // R2 R4 R5 R7
               core_next.count = COUNT_RESET_VAL;
            end else if (tb_fall) begin
               // Wraps after 255 so free-running continues
               core_next.count = COUNT_W'(core_reg.count + 1'b1); // R1 R12
            end
         end
         default: begin
            core_next.ctrl = ST_RESET;
            core_next.count = COUNT_RESET_VAL;
         end
      endcase

      // Internal oscillator only runs while triggered and enabled
      core_next.run = (core_next.ctrl != ST_RESET) &&
         !timebase_disable_i; // R2 R13
      if (!core_next.run) begin
         core_next.tbo_oe = 1'b0; // R2
      end else if (!core_reg.run) begin
         // Starts with the falling half so the first period opens at once
         core_next.tbo_oe = 1'b1; // R3
      end else if (tb_link.half_tick) begin
         core_next.tbo_oe = ~core_reg.tbo_oe;
      end

      core_next.q_oe = pull_low(core_next.ctrl,
         core_next.count); // R9 R10 R11 R16 R17
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         core_reg.ctrl <= ST_RESET; // R8
         core_reg.count <= COUNT_RESET_VAL; // R8
         core_reg.tb_prev <= 1'b1;
         core_reg.q_oe <= '0; // R8
         core_reg.tbo_oe <= 1'b0;
         core_reg.run <= 1'b0; // R8
         core_reg.init_done <= 1'b0;
      end else begin
         core_reg <= core_next;
      end
   end

   // ==========================================================
   // Pins: open-collector, only ever drive low
   assign binary_count_outputs_o = '0;
   assign binary_count_outputs_oe_o = core_reg.q_oe;
   assign timebase_pulse_out_o = 1'b0;
   assign timebase_pulse_out_oe_o = core_reg.tbo_oe;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!reset_n_i);

   chk_count_hold: assert property ( // R1
      (core_reg.ctrl == ST_COUNT) && !tb_fall && !reset_accept
      |=> core_reg.count == $past(core_reg.count))
      else $error("count moved without a falling edge");

   chk_count_step: assert property ( // R1
      (core_reg.ctrl == ST_COUNT) && tb_fall && !reset_accept
      |=> core_reg.count == COUNT_W'($past(core_reg.count) + 1'b1))
      else $error("count did not step on falling edge");

   chk_reset_release: assert property ( // R2
      core_reg.ctrl == ST_RESET
      |-> core_reg.q_oe == '0 && !core_reg.tbo_oe && !core_reg.run)
      else $error("outputs driven or oscillator running in reset");

   chk_first_fall: assert property ( // R3
      (core_reg.ctrl == ST_ARMED) && tb_fall && !reset_accept
      |=> core_reg.ctrl == ST_COUNT && core_reg.q_oe == 8'hFF)
      else $error("first fall did not pull all outputs low");

   chk_trigger_start: assert property ( // R3
      (core_reg.ctrl == ST_RESET) && trigger_i && !timebase_disable_i
      ##1 !reset_accept
      |-> core_reg.run && core_reg.tbo_oe)
      else $error("trigger did not start the oscillator");

   chk_trigger_ignored: assert property ( // R4
      (core_reg.ctrl == ST_COUNT) && !reset_accept
      |=> core_reg.ctrl == ST_COUNT)
      else $error("counting left without a reset");

   chk_reset_taken: assert property ( // R5
      (core_reg.ctrl != ST_RESET) && reset_req_i && !trigger_i
      |=> core_reg.ctrl == ST_RESET ##1 core_reg.q_oe == '0)
      else $error("reset with trigger low was not taken");

   chk_reset_blocked: assert property ( // R6
      (core_reg.ctrl == ST_COUNT) && reset_req_i && trigger_i
      |=> core_reg.ctrl == ST_COUNT)
      else $error("reset taken while trigger high");

   chk_reset_late: assert property ( // R7
      (core_reg.ctrl != ST_RESET) && trigger_i && reset_req_i
      ##1 !trigger_i && reset_req_i
      |=> core_reg.ctrl == ST_RESET)
      else $error("held reset not taken when trigger fell");

   chk_power_up: assert property ( // R8
      !core_reg.init_done
      |-> core_reg.ctrl == ST_RESET && core_reg.q_oe == '0)
      else $error("not in reset state after power-up");

   chk_bit_map: assert property ( // R9
      core_reg.ctrl == ST_COUNT |-> core_reg.q_oe == ~core_reg.count)
      else $error("output drive does not match count bits");

   chk_inhibit_hold: assert property ( // R13
      (core_reg.ctrl == ST_COUNT) && !core_reg.tb_prev && !timebase_i
      && !reset_accept
      |=> core_reg.count == $past(core_reg.count))
      else $error("count moved while the pin was held low");

   chk_osc_toggle: assert property ( // R16
      core_reg.run && tb_link.half_tick && core_next.run
      |=> core_reg.tbo_oe != $past(core_reg.tbo_oe))
      else $error("time base did not toggle on half tick");

   // ==========================================================
   // Checks on state, drive and oscillator
   // Some also read pin inputs, not registered state alone, so pin glitches can trip them
   chk_reset_count: assert property ( // R2
      core_reg.ctrl == ST_RESET
      |-> core_reg.count == COUNT_RESET_VAL)
      else $error("count not at its reset value in reset state");

   chk_armed_quiet: assert property ( // R3
      core_reg.ctrl == ST_ARMED
      |-> core_reg.q_oe == '0 && core_reg.count == COUNT_RESET_VAL)
      else $error("outputs pulled low before the first fall");

   chk_idle_stays: assert property ( // R3
      (core_reg.ctrl == ST_RESET) && !trigger_i
      |=> core_reg.ctrl == ST_RESET)
      else $error("reset state left without a trigger");

   chk_trigger_arms: assert property ( // R3
      (core_reg.ctrl == ST_RESET) && trigger_i
      |=> core_reg.ctrl == ST_ARMED)
      else $error("trigger in reset state was not taken");

   chk_armed_wait: assert property ( // R3
      (core_reg.ctrl == ST_ARMED) && !tb_fall && !reset_accept
      |=> core_reg.ctrl == ST_ARMED)
      else $error("armed state left without a fall or reset");

   chk_trigger_no_clear: assert property ( // R4
      (core_reg.ctrl == ST_COUNT) && trigger_i && !tb_fall
      |=> $stable(core_reg.count))
      else $error("trigger while counting disturbed the count");

   chk_reset_drops: assert property ( // R5
      (core_reg.ctrl != ST_RESET) && reset_accept
      |=> core_reg.q_oe == '0 && !core_reg.tbo_oe && !core_reg.run)
      else $error("accepted reset left a pin driven or oscillator on");

   chk_osc_off: assert property ( // R2
      !core_reg.run
      |-> !core_reg.tbo_oe)
      else $error("time-base pin driven while oscillator stopped");

   chk_run_state: assert property ( // R2
      core_reg.run
      |-> core_reg.ctrl != ST_RESET)
      else $error("oscillator running in reset state");

   chk_disable_stop: assert property ( // R13
      timebase_disable_i
      |=> !core_reg.run && !core_reg.tbo_oe)
      else $error("internal time base ran while disabled");

   chk_ext_step: assert property ( // R13
      (core_reg.ctrl == ST_COUNT) && timebase_disable_i && tb_fall
      && !reset_accept
      |=> core_reg.count == COUNT_W'($past(core_reg.count) + 1'b1))
      else $error("external clock fall did not advance the count");

   chk_rise_ignored: assert property ( // R1
      (core_reg.ctrl == ST_COUNT) && !core_reg.tb_prev && timebase_i
      && !reset_accept
      |=> $stable(core_reg.count))
      else $error("count moved on a rising edge");

   chk_half_steady: assert property ( // R16
      core_reg.run && core_next.run && !tb_link.half_tick
      |=> $stable(core_reg.tbo_oe))
      else $error("time base toggled between half ticks");
endmodule

/* File: verification/tbc_far_side.sv */
// Far-side model: trigger and reset sources, pulled-up pins, feedback
module tbc_far_side
   import tbc_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic trig_lvl_i,
   input wire logic rst_lvl_i,
   input wire logic ext_low_i,
   input wire logic [7:0] fb_mask_i,
   input wire logic [7:0] cnt_oe_i,
   input wire logic tbo_oe_i,
   output logic trigger_o,
   output logic reset_req_o,
   output logic timebase_o,
   output logic [7:0] pins_o,
   output logic wired_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import tbc_pkg::*;
   int unsigned t_cnt = 0;
   int unsigned r_cnt = 0;
   // ==========================================================
   // Pulse stretch
   // Short requests are widened so the device never sees a runt
   always @(posedge clk_sys_i) begin
      t_cnt <= trig_lvl_i ? TRIG_MIN_CYCLES :
         ((t_cnt != 0) ? t_cnt - 1 : 0);
      r_cnt <= rst_lvl_i ? TRIG_MIN_CYCLES :
         ((r_cnt != 0) ? r_cnt - 1 : 0);
   end
   // ==========================================================
   // Wires with pull-ups
   assign pins_o = ~cnt_oe_i;
   assign wired_o = &(pins_o | ~fb_mask_i);
   assign timebase_o = ~(tbo_oe_i | ext_low_i);
   assign trigger_o = trig_lvl_i | (t_cnt != 0);
   assign reset_req_o = rst_lvl_i | (r_cnt != 0) |
      ((|fb_mask_i) & wired_o);
endmodule

/* File: verification/tb.sv */
// Testbench for the triggered binary timer/counter
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import tbc_pkg::*;
   logic clk_sys_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic trig_lvl = 1'b0, rst_lvl = 1'b0, ext_low = 1'b0, tb_dis = 1'b0;
   logic [7:0] fb_mask = 8'h00;
   logic trigger, reset_req, timebase, wired, tbo_oe, tbo_d;
   logic [7:0] pins, cnt_oe, cnt_d;
   int mismatches = 0;
   int checked = 0;
   always #(CLK_PERIOD_NS / 2) clk_sys_i = ~clk_sys_i;
   tbc_top u_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .trigger_i(trigger), .reset_req_i(reset_req), .timebase_i(timebase),
      .timebase_disable_i(tb_dis), .binary_count_outputs_o(cnt_d),
      .binary_count_outputs_oe_o(cnt_oe), .timebase_pulse_out_o(tbo_d),
      .timebase_pulse_out_oe_o(tbo_oe));
   tbc_far_side u_far (.clk_sys_i(clk_sys_i), .trig_lvl_i(trig_lvl),
      .rst_lvl_i(rst_lvl), .ext_low_i(ext_low), .fb_mask_i(fb_mask),
      .cnt_oe_i(cnt_oe), .tbo_oe_i(tbo_oe), .trigger_o(trigger),
      .reset_req_o(reset_req), .timebase_o(timebase), .pins_o(pins),
      .wired_o(wired));
   // ==========================================================
   // Helpers
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Lengths carry a little slack for edge detection
   task automatic cmp_len(input int got, input int exp);
      checked++;
      if (got < exp - 3 || got > exp + 3) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   task automatic wait_lvl(input int sel, input logic v, output int n);
      n = 0;
      while ((sel == 0 ? tbo_oe : sel == 1 ? wired : trigger) !== v &&
             n < 40000) begin
         @(negedge clk_sys_i);
         n++;
      end
      if (n >= 40000) cmp(32'h0, 32'h1);
   endtask
   task automatic pulse_trig();
      trig_lvl = 1'b1;
      @(negedge clk_sys_i);
      trig_lvl = 1'b0;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_powerup();
      cmp({cnt_oe, tbo_oe}, 9'h000);
      cmp({cnt_d, tbo_d}, 9'h000);
      wait_cyc(2000);
      cmp({cnt_oe, tbo_oe}, 9'h000);
      $display("test powerup done");
   endtask
   task automatic t_count();
      int n;
      pulse_trig();
      wait_cyc(5);
      cmp(pins, 8'h00);
      for (int k = 1; k < 5; k++) begin
         wait_lvl(0, 1'b0, n);
         wait_cyc(10);
         cmp(pins, 8'(k - 1));
         if (k == 2) pulse_trig();
         wait_lvl(0, 1'b1, n);
         wait_cyc(10);
         cmp(pins, 8'(k));
      end
      $display("test count done");
   endtask
   task automatic t_gate();
      int n;
      trig_lvl = 1'b1;
      rst_lvl = 1'b1;
      wait_cyc(20);
      cmp(pins, 8'h04);
      trig_lvl = 1'b0;
      wait_lvl(2, 1'b0, n);
      wait_cyc(3);
      cmp({pins, tbo_oe}, {8'hFF, 1'b0});
      rst_lvl = 1'b0;
      wait_cyc(1500);
      cmp(tbo_oe, 1'b0);
      $display("test gate done");
   endtask
   task automatic t_mono();
      int n;
      fb_mask = 8'h20;
      pulse_trig();
      wait_lvl(1, 1'b0, n);
      wait_lvl(1, 1'b1, n);
      cmp_len(n, 32 * 2 * TB_HALF_CYCLES);
      wait_cyc(3);
      cmp(pins, 8'hFF);
      fb_mask = 8'h00;
      $display("test mono done");
   endtask
   task automatic t_ext();
      tb_dis = 1'b1;
      fb_mask = 8'h31;
      pulse_trig();
      wait_cyc(5);
      for (int k = 1; k <= 50; k++) begin
         ext_low = 1'b1;
         wait_cyc(k == 20 ? 1000 : EXT_CLK_MIN_CYCLES);
         if (k == 20) cmp(pins, 8'h13);
         ext_low = 1'b0;
         wait_cyc(EXT_CLK_MIN_CYCLES);
         if (k == 49) cmp(wired, 1'b0);
      end
      cmp(pins, 8'hFF);
      fb_mask = 8'h00;
      tb_dis = 1'b0;
      $display("test ext done");
   endtask
   task automatic t_midreset();
      pulse_trig();
      wait_cyc(1200);
      cmp(pins, 8'h01);
      reset_n_i = 1'b0;
      wait_cyc(2);
      cmp({pins, tbo_oe}, {8'hFF, 1'b0});
      reset_n_i = 1'b1;
      wait_cyc(2);
      cmp({pins, tbo_oe, timebase}, {8'hFF, 1'b0, 1'b1});
      $display("test midreset done");
   endtask
   // ==========================================================
   // Run control
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge clk_sys_i);
      reset_n_i = 1'b1;
      @(negedge clk_sys_i);
      t_powerup();
      t_count();
      t_gate();
      t_mono();
      t_ext();
      t_midreset();
      give_verdict();
   end
   // Tests need about 54000 cycles
   initial begin
      repeat (80000) @(posedge clk_sys_i);
      mismatches++;
      give_verdict();
   end
endmodule
